// *** rtl/flash_option_byte_loader.v ***
// flash option byte loader: fetch, hold and decode of the user option bytes
//
// Function
// - every reset or stop recovery reloads both option bytes before the core runs
// - changed option bytes only take effect after the next reload
// - option holding registers are invisible to the register port
// - first byte bit 7: clear gives watchdog interrupt, set gives system reset
// - first byte bit 6 clear: watchdog runs from power-up, cannot be disabled
// - bit 6 set: watchdog starts on arm instruction, stays on until reset or stop recovery
// - first byte bits 5:4 select oscillator drive: RC, low, medium, high
// - bit 3 clear: brown-out off in stop only if power control bit set
// - bit 3 set: brown-out protection always on, stop mode included
// - bit 2 clear: code reads blocked, debugger limited
// - bit 2 set: code readable, all debugger commands allowed
// - bit 0 clear: user program, page erase and mass erase refused
// - debugger mass erase still accepted under write protection
// - bit 0 set: program and erase allowed everywhere
// - second byte bit 4 gates the crystal only, never the clock source
// - bit 4 clear: crystal runs during reset; set: crystal off during reset
`timescale 1ns/100ps
`default_nettype none
`include "option_loader_map.vh"

module flash_option_byte_loader (
  input wire clk, // system clock, 250 MHz
  input wire rst_n, // power-on / pin reset, asynchronous, active low
  input wire sys_reset_req, // system reset request pulse, same clock
  input wire stop_recovery, // stop-mode recovery pulse, same clock
  input wire stop_mode, // core is in stop mode
  input wire watchdog_arm_instr, // pulse: watchdog instruction executed
  input wire xtal_sw_enable, // software crystal enable after reset
  input wire user_prog_req, // user code program request pulse
  input wire user_page_erase_req, // user code page erase request pulse
  input wire user_mass_erase_req, // user code mass erase request pulse
  input wire debug_mass_erase, // debugger mass erase level, foreign domain
  input wire [`FLASH_AW-1:0] flash_rdata_unused_w, // reserved, not read
  input wire [7:0] flash_rdata, // flash read data, valid while flash_rd is high
  input wire [`REG_AW-1:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  input wire reg_wr, // register write strobe
  input wire reg_rd, // register read strobe
  output reg [7:0] reg_rdata, // register read data, cycle after reg_rd
  output reg flash_rd, // flash read strobe
  output reg [`FLASH_AW-1:0] flash_addr, // flash read address
  output reg core_reset_hold, // holds the core in reset while loading
  output reg wdt_timeout_action, // 1 = time-out resets, 0 = interrupt
  output reg wdt_enable, // watchdog running
  output reg [1:0] osc_drive_select, // oscillator drive mode
  output reg brownout_enable, // brown-out detector powered
  output reg code_read_allow, // user code may be read
  output reg debug_full_access, // all debugger commands allowed
  output reg xtal_enable, // crystal oscillator running
  output reg prog_grant, // program operation accepted
  output reg page_erase_grant, // page erase accepted
  output reg mass_erase_grant, // mass erase accepted
  output reg write_refused // pulse: user program/erase refused
);

  // ----------------------------------------------------------------
  // loader states
  // ----------------------------------------------------------------
  localparam [2:0] S_FETCH0 = 3'b000;
  localparam [2:0] S_FETCH1 = 3'b001;
  localparam [2:0] S_LATCH1 = 3'b010;
  localparam [2:0] S_XTAL = 3'b011;
  localparam [2:0] S_RUN = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`XTAL_CW-1:0] xtal_count;
  reg [7:0] option_config_byte0;
  reg [7:0] option_config_byte1;
  reg loaded;
  reg wdt_armed;
  reg bo_stop_off;
  reg refused_flag;
  reg dbg_last;
  wire dbg_level;
  wire dbg_pulse;
  wire reload;
  wire wr_ok;
  wire wdt_forced;
  wire any_user_req;

  // ----------------------------------------------------------------
  // debugger request crossing
  // ----------------------------------------------------------------
  pin_sync3 dbg_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(debug_mass_erase),
    .sync_out(dbg_level)
  );

  assign dbg_pulse = dbg_level & ~dbg_last;

  // ----------------------------------------------------------------
  // load sequencer
  // ----------------------------------------------------------------
  assign reload = sys_reset_req | stop_recovery;

  always @* begin
    next_state = state;
    case (state)
      S_FETCH0: begin
        next_state = S_FETCH1;
      end
      S_FETCH1: begin
        next_state = S_LATCH1;
      end
      S_LATCH1: begin
        if (flash_rdata[`OB1_XTAL_OFF]) begin
          next_state = S_RUN;
        end else begin
          next_state = S_XTAL;
        end
      end
      S_XTAL: begin
        if (xtal_count == `XTAL_LAST) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        if (reload) begin
          next_state = S_FETCH0;
        end
      end
      default: begin
        next_state = S_FETCH0;
      end
    endcase
  end

  // byte 0 is requested in FETCH0 and lands in FETCH1, byte 1 lands in LATCH1
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_FETCH0;
      flash_rd <= 1'b0;
      flash_addr <= `OPT_ADDR0;
      option_config_byte0 <= `OPT_ERASED;
      option_config_byte1 <= `OPT_ERASED;
      loaded <= 1'b0;
      core_reset_hold <= 1'b1;
      xtal_count <= {`XTAL_CW{1'b0}};
    end else begin
      state <= next_state;
      flash_rd <= 1'b0;
      case (state)
        S_FETCH0: begin
          flash_rd <= 1'b1;
          flash_addr <= `OPT_ADDR0;
          loaded <= 1'b0;
          core_reset_hold <= 1'b1;
        end
        S_FETCH1: begin
          option_config_byte0 <= flash_rdata;
          flash_rd <= 1'b1;
          flash_addr <= `OPT_ADDR1;
        end
        S_LATCH1: begin
          option_config_byte1 <= flash_rdata;
          xtal_count <= {`XTAL_CW{1'b0}};
          if (flash_rdata[`OB1_XTAL_OFF]) begin
            loaded <= 1'b1;
            core_reset_hold <= 1'b0;
          end
        end
        S_XTAL: begin
          // crystal runs while the core waits: the price is a longer reset
          xtal_count <= xtal_count + 1'b1;
          if (xtal_count == `XTAL_LAST) begin
            loaded <= 1'b1;
            core_reset_hold <= 1'b0;
          end
        end
        S_RUN: begin
          // bytes are frozen here; flash edits wait for the next reload
          if (reload) begin
            core_reset_hold <= 1'b1;
            loaded <= 1'b0;
          end
        end
        default: begin
          core_reset_hold <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decoded option fields
  // ----------------------------------------------------------------
  // reserved bits of both bytes are ignored whatever was programmed
  assign wdt_forced = ~option_config_byte0[`OB0_WDT_FORCE];
  assign wr_ok = option_config_byte0[`OB0_WRITE_GUARD];
  assign any_user_req = user_prog_req | user_page_erase_req | user_mass_erase_req;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_armed <= 1'b0;
      wdt_enable <= 1'b0;
      wdt_timeout_action <= 1'b1;
      osc_drive_select <= `OSC_RESET;
      brownout_enable <= 1'b1;
      code_read_allow <= 1'b0;
      debug_full_access <= 1'b0;
      xtal_enable <= 1'b0;
      dbg_last <= 1'b0;
    end else begin
      dbg_last <= dbg_level;
      // the arm latch only falls on reset or stop recovery
      if (reload || !loaded) begin
        wdt_armed <= 1'b0;
      end else if (watchdog_arm_instr) begin
        wdt_armed <= 1'b1;
      end
      // software has no path that clears a forced watchdog
      wdt_enable <= loaded & (wdt_forced | wdt_armed);
      wdt_timeout_action <= option_config_byte0[`OB0_WDT_ACTION];
      osc_drive_select <= {option_config_byte0[`OB0_OSC_HI],
                           option_config_byte0[`OB0_OSC_LO]};
      brownout_enable <= option_config_byte0[`OB0_BO_KEEP] |
                         ~(stop_mode & bo_stop_off);
      // guard stays closed until a fresh copy of the bytes is in
      code_read_allow <= loaded & option_config_byte0[`OB0_READ_GUARD];
      debug_full_access <= loaded & option_config_byte0[`OB0_READ_GUARD];
      // before byte 1 lands the last latched byte 1 applies (erased, crystal off, after rst_n)
      if (core_reset_hold) begin
        xtal_enable <= ~option_config_byte1[`OB1_XTAL_OFF];
      end else begin
        xtal_enable <= xtal_sw_enable;
      end
    end
  end

  // ----------------------------------------------------------------
  // program and erase gating
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_grant <= 1'b0;
      page_erase_grant <= 1'b0;
      mass_erase_grant <= 1'b0;
      write_refused <= 1'b0;
    end else begin
      prog_grant <= loaded & wr_ok & user_prog_req;
      page_erase_grant <= loaded & wr_ok & user_page_erase_req;
      mass_erase_grant <= (loaded & wr_ok & user_mass_erase_req) | dbg_pulse;
      write_refused <= any_user_req & ~(loaded & wr_ok);
    end
  end

  // ----------------------------------------------------------------
  // register port: power control and status only
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bo_stop_off <= 1'b0;
      refused_flag <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `REG_PWR_CTL) begin
        bo_stop_off <= reg_wdata[`PWR_BO_STOP_OFF];
      end
      // a new refusal wins over a clear in the same cycle
      if (write_refused) begin
        refused_flag <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS && reg_wdata[`STAT_REFUSED]) begin
        refused_flag <= 1'b0;
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        // option holding registers have no address here
        if (reg_addr == `REG_PWR_CTL) begin
          reg_rdata <= {7'h00, bo_stop_off};
        end else if (reg_addr == `REG_STATUS) begin
          reg_rdata <= {5'h00, wdt_enable, refused_flag, loaded};
        end else begin
          reg_rdata <= 8'h00;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/option_loader_map.vh ***
// constants for the flash option byte loader
`ifndef OPTION_LOADER_MAP_VH
`define OPTION_LOADER_MAP_VH

// ----------------------------------------------------------------
// flash locations of the two user option bytes
// ----------------------------------------------------------------
`define FLASH_AW 16
`define OPT_ADDR0 16'h0000
`define OPT_ADDR1 16'h0001
`define OPT_ERASED 8'hff

// ----------------------------------------------------------------
// first option byte fields
// ----------------------------------------------------------------
`define OB0_WDT_ACTION 7
`define OB0_WDT_FORCE 6
`define OB0_OSC_HI 5
`define OB0_OSC_LO 4
`define OB0_BO_KEEP 3
`define OB0_READ_GUARD 2
`define OB0_WRITE_GUARD 0

// ----------------------------------------------------------------
// second option byte fields
// ----------------------------------------------------------------
`define OB1_XTAL_OFF 4

// ----------------------------------------------------------------
// loader-owned register port
// ----------------------------------------------------------------
`define REG_AW 4
`define REG_PWR_CTL 4'h0
`define REG_STATUS 4'h1
`define PWR_BO_STOP_OFF 0
`define STAT_LOADED 0
`define STAT_REFUSED 1
`define STAT_WDT_ON 2

// ----------------------------------------------------------------
// crystal start-up wait and decoded reset values
// ----------------------------------------------------------------
`define XTAL_CW 5
`define XTAL_LAST 5'h0f
`define OSC_RESET 2'h3

`endif

// *** rtl/pin_sync3.v ***
// three-flop synchroniser with agreement filter for an asynchronous level
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 (
  input wire clk, // system clock
  input wire rst_n, // asynchronous reset, active low
  input wire async_in, // level from another clock domain
  output reg sync_out // filtered level on clk
);

  reg s1;
  reg s2;
  reg s3;

  // s1 only feeds s2; the filter compares the later two stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        sync_out <= s3;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/flash_model.sv ***
// flash array model holding the two option bytes
`timescale 1ns/100ps
`default_nettype none
module flash_model (
  input wire logic rd, // read strobe
  input wire logic [15:0] addr, // address
  output logic [7:0] rdata // data, valid while rd is high
);
  // ----
  // array
  // ----
  logic [7:0] mem [0:1] = '{8'hff, 8'hff};
  // outside a read the bus shows the inverse, so a mistimed sample is caught
  always_comb begin
    rdata = rd ? mem[addr[0]] : ~mem[addr[0]];
  end
endmodule
`default_nettype wire

// *** tb/flash_option_byte_loader_chk.sv ***
// port checker for the option byte loader
`timescale 1ns/100ps
`default_nettype none
module flash_option_byte_loader_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic sys_reset_req, // reload
  input wire logic stop_recovery, // reload
  input wire logic stop_mode, // stop
  input wire logic user_prog_req, // req
  input wire logic user_page_erase_req, // req
  input wire logic reg_rd, // read
  input wire logic [7:0] reg_rdata, // data
  input wire logic flash_rd, // fetch
  input wire logic [15:0] flash_addr, // addr
  input wire logic core_reset_hold, // hold
  input wire logic wdt_enable, // wdt
  input wire logic brownout_enable, // bo
  input wire logic prog_grant, // grant
  input wire logic page_erase_grant, // grant
  input wire logic write_refused // refusal
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_second;
    flash_rd && flash_addr == 16'h0001 ##1 !flash_rd ##[0:20] !core_reset_hold;
  endsequence
  property p_fetch; flash_rd && flash_addr == 16'h0000 |=> s_second; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch order wrong");
  property p_hold; flash_rd |-> core_reset_hold; endproperty
  a_hold: assert property (p_hold) else $error("fetch outside hold");
  property p_reload; (sys_reset_req || stop_recovery) && !core_reset_hold |=> core_reset_hold;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_prog; user_prog_req |=> prog_grant != write_refused; endproperty
  a_prog: assert property (p_prog) else $error("program answer wrong");
  property p_page; user_page_erase_req |=> page_erase_grant != write_refused; endproperty
  a_page: assert property (p_page) else $error("erase answer wrong");
  property p_cause; prog_grant |-> $past(user_prog_req); endproperty
  a_cause: assert property (p_cause) else $error("grant without request");
  property p_wdt; wdt_enable && !core_reset_hold && !sys_reset_req && !stop_recovery
    |=> wdt_enable; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog dropped");
  property p_bo; !stop_mode && !$past(stop_mode) |-> brownout_enable; endproperty
  a_bo: assert property (p_bo) else $error("brown-out off outside stop");
  property p_rd; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
endmodule
bind flash_option_byte_loader flash_option_byte_loader_chk i_chk (.clk, .rst_n,
  .sys_reset_req, .stop_recovery, .stop_mode, .user_prog_req, .user_page_erase_req,
  .reg_rd, .reg_rdata, .flash_rd, .flash_addr, .core_reset_hold, .wdt_enable,
  .brownout_enable, .prog_grant, .page_erase_grant, .write_refused);
`default_nettype wire

// *** tb/test_flash_option_byte_loader.sv ***
// self-checking bench for the option byte loader
`timescale 1ns/100ps
`default_nettype none
module test_flash_option_byte_loader;
  logic clk = 0, rst_n = 0, sys_reset_req = 0, stop_recovery = 0, stop_mode = 0;
  logic watchdog_arm_instr = 0, xtal_sw_enable = 0, debug_mass_erase = 0;
  logic user_prog_req = 0, user_page_erase_req = 0, user_mass_erase_req = 0;
  logic reg_wr = 0, reg_rd = 0, flash_rd, core_reset_hold, wdt_timeout_action, wdt_enable;
  logic brownout_enable, code_read_allow, debug_full_access, xtal_enable, prog_grant;
  logic page_erase_grant, mass_erase_grant, write_refused;
  logic [1:0] osc_drive_select;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, flash_rdata, b0, b1, d;
  logic [15:0] flash_addr, flash_rdata_unused_w = 0;
  int errors = 0, n_checks = 0, i;
  always #2 clk = ~clk;
  flash_option_byte_loader i_flash_option_byte_loader (.clk, .rst_n, .sys_reset_req,
    .stop_recovery, .stop_mode, .watchdog_arm_instr, .xtal_sw_enable, .user_prog_req,
    .user_page_erase_req, .user_mass_erase_req, .debug_mass_erase, .flash_rdata_unused_w,
    .flash_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_rd,
    .flash_addr, .core_reset_hold, .wdt_timeout_action, .wdt_enable, .osc_drive_select,
    .brownout_enable, .code_read_allow, .debug_full_access, .xtal_enable, .prog_grant,
    .page_erase_grant, .mass_erase_grant, .write_refused);
  flash_model i_flash_model (.rd(flash_rd), .addr(flash_addr), .rdata(flash_rdata));
  // ----
  // tasks
  // ----
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1;
    d = reg_rdata;
  endtask
  // bounded wait for the loader to release the core
  task settle;
    i = 0;
    #1;
    while (core_reset_hold !== 1'b0 && i < 40) begin
      tick(1);
      i++;
    end
    if (core_reset_hold !== 1'b0) begin
      errors++;
      results;
    end
    tick(1);
  endtask
  task load(input int how);
    i_flash_model.mem[0] = b0;
    i_flash_model.mem[1] = b1;
    @(posedge clk);
    if (how == 0) sys_reset_req <= 1;
    else stop_recovery <= 1;
    @(posedge clk);
    sys_reset_req <= 0;
    stop_recovery <= 0;
    tick(6);
    chk("long reset", core_reset_hold, !b1[4]);
    chk("xtal in reset", xtal_enable, b1[4] ? xtal_sw_enable : 1'b1);
    settle;
  endtask
  task check_outs(input logic w);
    chk("timeout action", wdt_timeout_action, b0[7]);
    chk("watchdog", wdt_enable, w);
    chk("osc drive", osc_drive_select, b0[5:4]);
    chk("brownout", brownout_enable, 1);
    chk("code read", code_read_allow, b0[2]);
    chk("debug access", debug_full_access, b0[2]);
    chk("xtal", xtal_enable, xtal_sw_enable);
  endtask
  task req(input int k);
    @(posedge clk);
    {user_mass_erase_req, user_page_erase_req, user_prog_req} <= 3'(1 << k);
    @(posedge clk);
    {user_mass_erase_req, user_page_erase_req, user_prog_req} <= 3'b000;
    #1;
    chk("grants", {mass_erase_grant, page_erase_grant, prog_grant}, 8'(b0[0]) << k);
    chk("refused", write_refused, !b0[0]);
  endtask
  task exercise;
    wr(4'h1, 8'h02);
    for (int k = 0; k < 3; k++) req(k);
    @(posedge clk);
    stop_mode <= 1;
    tick(2);
    chk("stop bo", brownout_enable, 1);
    wr(4'h0, 8'h01);
    tick(2);
    chk("stop bo off", brownout_enable, b0[3]);
    @(posedge clk);
    stop_mode <= 0;
    wr(4'h0, 8'h00);
    @(posedge clk);
    watchdog_arm_instr <= 1;
    @(posedge clk);
    watchdog_arm_instr <= 0;
    rd(4'h1);
    chk("status", d, {5'b0, 1'b1, !b0[0], 1'b1});
    wr(4'h7, 8'hff);
    rd(4'h7);
    chk("unmapped", d, 0);
    i_flash_model.mem[0] = ~b0;
    tick(3);
    check_outs(1'b1);
  endtask
  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(32'hdb14));
    b0 = 8'hff;
    b1 = 8'hff;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    settle;
    check_outs(0);
    $display("test erased done");
    for (int it = 0; it < 8; it++) begin
      b0 = 8'($urandom);
      b0[5:4] = 2'(it);
      b0[1] = 1'b1;
      b1 = 8'($urandom) | 8'hef;
      @(posedge clk);
      xtal_sw_enable <= 1'($urandom);
      load(it % 2);
      check_outs(!b0[6]);
      exercise;
      $display("test %0d done", it);
    end
    b0 = 8'hfe;
    load(0);
    @(posedge clk);
    debug_mass_erase <= 1;
    i = 0;
    while (mass_erase_grant !== 1'b1 && i < 12) begin
      tick(1);
      i++;
    end
    chk("debug erase", 8'(i < 12), 1);
    $display("test debug erase done");
    results;
  end
endmodule
`default_nettype wire
